// ===== inc/iep_pkg.sv
// Package of constants for the interrupt enable and priority bank
package iep_pkg;
    // Register map, word offsets on the plain register port
    localparam logic [7:0] OFS_FLAG = 8'h00;
    localparam logic [7:0] OFS_ENABLE = 8'h04;
    localparam logic [7:0] OFS_PRIO0 = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h30;
    // Priority word field layout, slot n sits at n*SLOT_STRIDE
    localparam int SLOT_STRIDE = 8;
    localparam int PRI_LSB = 2;
    localparam int PRI_W = 3;
    localparam int SUB_LSB = 0;
    localparam int SUB_W = 2;
    localparam logic [31:0] PRIO_WMASK = 32'h1F1F1F1F;
    localparam int STATUS_PRI_LSB = 8;
    localparam logic [31:0] RESET_WORD = 32'h00000000;
    localparam logic [2:0] PRI_OFF = 3'h0;
    localparam int SLOTS_PER_WORD = 4;
endpackage : iep_pkg

// ===== hdl/iep_slot_rank.sv
// Rank key of one source: eligibility, priority and subpriority
`timescale 1ns/10ps
module iep_slot_rank (
    input wire logic flag,
    input wire logic enable,
    input wire logic [2:0] priority_level,
    input wire logic [1:0] subpriority_level,
    output logic eligible,
    output logic [4:0] rank
);
    // Zero priority blocks the source whatever its enable says
    always_comb begin
        eligible = flag && enable && (priority_level != iep_pkg::PRI_OFF);
        rank = {priority_level, subpriority_level};
    end
endmodule : iep_slot_rank

// ===== hdl/iep_bank.sv
// Interrupt source enable, priority bank and request resolver
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/10ps
// Operation
// - Each enable bit lets its source request service when one and blocks it when zero.
// - All implemented enable and priority bits are software read/write and reset to zero.
// - Priority fields sit at bits 28-26, 20-18, 12-10 and 4-2 for slots three to zero.
// - Subpriority fields sit just below, at 25-24, 17-16, 9-8 and 1-0.
// - A priority of zero disables its source regardless of the enable bit.
// - Nonzero priorities are levels one to seven in binary, seven the highest.
// - Subpriorities are levels zero to three in binary and break priority ties.
// - The three bits above each priority field ignore writes and read as zero.
// - A source flag is set by the device when the source raises a request.
// - The level of the latest request presented to the core is kept in a 3-bit status field.
module iep_bank #(
    parameter int NSRC = 32
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [NSRC-1:0] src_req,
    output logic irq_valid,
    output logic [4:0] irq_source,
    output logic [2:0] irq_priority,
    output logic [1:0] irq_subpriority
);
    // Priority words needed when every word carries four slots
    localparam int NPW = NSRC / iep_pkg::SLOTS_PER_WORD;

    // Field slicing and the 5-bit source number only fit exactly 32 sources
    if (NSRC != 32) begin : g_nsrc_check
        $error("iep_bank serves exactly 32 sources");
    end

    // Register state; flags are set by hardware and cleared by software writes
    logic [31:0] flag_word, next_flag_word;
    logic [31:0] source_enable_word, next_source_enable_word;
    logic [31:0] source_priority_word [NPW];
    logic [31:0] next_source_priority_word [NPW];
    logic [2:0] presented_priority_level, next_presented_priority_level;
    logic [31:0] next_rdata;
    // Resolver nets
    logic [NSRC-1:0] elig;
    logic [4:0] rank [NSRC];
    logic [4:0] best_rank;
    logic [4:0] best_src;
    logic best_any;

    // Decode of a priority word index, or -1 when the address is elsewhere
    function automatic int prio_index(input logic [7:0] a);
        int idx;
        idx = -1;
        if (a >= iep_pkg::OFS_PRIO0 && a < iep_pkg::OFS_PRIO0 + 8'(4 * NPW) && a[1:0] == 2'h0)
            idx = int'((a - iep_pkg::OFS_PRIO0) >> 2);
        return idx;
    endfunction : prio_index

    // One rank unit per source, fields picked from the packed priority words
    for (genvar s = 0; s < NSRC; s++) begin : g_src
        localparam int W = s / iep_pkg::SLOTS_PER_WORD;
        localparam int B = (s % iep_pkg::SLOTS_PER_WORD) * iep_pkg::SLOT_STRIDE;
        iep_slot_rank u_rank (
            .flag(flag_word[s]),
            .enable(source_enable_word[s]),
            .priority_level(source_priority_word[W][B+iep_pkg::PRI_LSB +: iep_pkg::PRI_W]),
            .subpriority_level(source_priority_word[W][B+iep_pkg::SUB_LSB +: iep_pkg::SUB_W]),
            .eligible(elig[s]),
            .rank(rank[s])
        );
    end

    // Pick highest rank; on a full tie the lower source number wins
    always_comb begin
        best_any = 1'b0;
        best_rank = 5'h00;
        best_src = 5'h00;
        for (int s = 0; s < NSRC; s++) begin
            if (elig[s] && (!best_any || rank[s] > best_rank)) begin
                best_any = 1'b1;
                best_rank = rank[s];
                best_src = 5'(s);
            end
        end
    end

    // Next register state: set from a request wins over a software clear
    always_comb begin
        next_flag_word = flag_word;
        next_source_enable_word = source_enable_word;
        next_presented_priority_level = presented_priority_level;
        for (int w = 0; w < NPW; w++) next_source_priority_word[w] = source_priority_word[w];
        if (reg_wr) begin
            if (reg_addr == iep_pkg::OFS_FLAG) next_flag_word = reg_wdata;
            if (reg_addr == iep_pkg::OFS_ENABLE) next_source_enable_word = reg_wdata;
            if (prio_index(reg_addr) >= 0)
                next_source_priority_word[prio_index(reg_addr)] =
                    reg_wdata & iep_pkg::PRIO_WMASK;
        end
        next_flag_word = next_flag_word | 32'(src_req);
        if (best_any) next_presented_priority_level = best_rank[4:2];
    end

    // Read mux; unmapped addresses read zero
    // Status sits above the last priority word so every priority word stays readable
    always_comb begin
        next_rdata = 32'h00000000;
        if (reg_rd) begin
            if (reg_addr == iep_pkg::OFS_FLAG) next_rdata = flag_word;
            else if (reg_addr == iep_pkg::OFS_ENABLE) next_rdata = source_enable_word;
            else if (reg_addr == iep_pkg::OFS_STATUS)
                next_rdata = 32'(presented_priority_level) << iep_pkg::STATUS_PRI_LSB;
            else if (prio_index(reg_addr) >= 0)
                next_rdata = source_priority_word[prio_index(reg_addr)];
        end
    end

    // Registers; clock enable freezes everything
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flag_word <= iep_pkg::RESET_WORD;
            source_enable_word <= iep_pkg::RESET_WORD;
            for (int w = 0; w < NPW; w++) source_priority_word[w] <= iep_pkg::RESET_WORD;
            presented_priority_level <= 3'h0;
            reg_rdata <= 32'h00000000;
            irq_valid <= 1'b0;
            irq_source <= 5'h00;
            irq_priority <= 3'h0;
            irq_subpriority <= 2'h0;
        end else if (clk_en) begin
            flag_word <= next_flag_word;
            source_enable_word <= next_source_enable_word;
            for (int w = 0; w < NPW; w++) source_priority_word[w] <= next_source_priority_word[w];
            presented_priority_level <= next_presented_priority_level;
            reg_rdata <= next_rdata;
            irq_valid <= best_any;
            irq_source <= best_src;
            irq_priority <= best_rank[4:2];
            irq_subpriority <= best_rank[1:0];
        end
    end

    // Checks; all sit on the core clock and stay quiet while reset is held
    // A zero priority field must keep its source away from the core
    a_zero_prio_blocks: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && $rose(irq_valid) |-> irq_priority != 3'h0)
        else $error("zero priority forwarded");
    a_zero_src_blocked: assert property (@(posedge core_clk) disable iff (!rst_n)
        flag_word[0] && source_enable_word[0]
        && source_priority_word[0][iep_pkg::PRI_LSB +: iep_pkg::PRI_W] == iep_pkg::PRI_OFF
        |-> !elig[0])
        else $error("zero priority source marked eligible");

    // Unimplemented bits are dropped on the way in, so they can only read zero
    a_unimpl_reads_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && reg_rd && prio_index(reg_addr) >= 0
        |=> (reg_rdata & ~iep_pkg::PRIO_WMASK) == 32'h00000000)
        else $error("unimplemented priority bits read nonzero");
    a_prio_write_masked: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && reg_wr && reg_addr == iep_pkg::OFS_PRIO0
        |=> source_priority_word[0] == ($past(reg_wdata) & iep_pkg::PRIO_WMASK))
        else $error("priority word 0 write not stored masked");

    // Enable bits are plain read/write storage that gates each source
    a_enable_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && reg_wr && reg_addr == iep_pkg::OFS_ENABLE
        |=> source_enable_word == $past(reg_wdata))
        else $error("enable word write not stored");
    a_enable_gates: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && best_any |-> source_enable_word[best_src] && flag_word[best_src])
        else $error("disabled or unflagged source chosen");
    a_enable_readback: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && reg_wr && reg_addr == iep_pkg::OFS_ENABLE ##1 clk_en && reg_rd
        && reg_addr == iep_pkg::OFS_ENABLE |=> reg_rdata == $past(reg_wdata, 2))
        else $error("enable word readback mismatch");

    // A low clock enable holds state; read data drops back to zero after a read
    a_freeze_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
        !clk_en |=> $stable(source_enable_word) && $stable(flag_word))
        else $error("state moved while clock enable was low");
    a_rdata_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && !reg_rd |=> reg_rdata == 32'h00000000)
        else $error("read data left standing without a read");

    // Flags follow the requests; status and the forwarded request follow the resolver
    a_flag_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && src_req[0] |=> flag_word[0])
        else $error("request did not set flag");
    a_status_tracks: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && best_any |=> presented_priority_level == $past(best_rank[4:2]))
        else $error("presented level not updated");
    a_status_idle_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && !best_any |=> $stable(presented_priority_level))
        else $error("presented level moved with nothing eligible");
    a_irq_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en |=> irq_valid == $past(best_any) && irq_source == $past(best_src))
        else $error("forwarded request does not follow the resolver");
    a_best_is_max: assert property (@(posedge core_clk) disable iff (!rst_n)
        best_any |-> best_rank >= rank[0] || !elig[0])
        else $error("lower rank chosen over source 0");
    a_sub_breaks_tie: assert property (@(posedge core_clk) disable iff (!rst_n)
        best_any && elig[1] |-> best_rank >= rank[1])
        else $error("lower rank chosen over source 1");
    a_fields_placed: assert property (@(posedge core_clk) disable iff (!rst_n)
        rank[3] == {source_priority_word[0][28:26], source_priority_word[0][25:24]})
        else $error("slot three fields misplaced");
    a_sub_slot_placed: assert property (@(posedge core_clk) disable iff (!rst_n)
        rank[2][1:0] == source_priority_word[0][17:16])
        else $error("slot two subpriority misplaced");

    // Main scenarios
    c_forward: cover property (@(posedge core_clk) irq_valid);
    c_prio_seven: cover property (@(posedge core_clk) irq_valid && irq_priority == 3'h7);
    c_tie_sub: cover property (@(posedge core_clk)
        elig[1] && elig[2] && rank[1][4:2] == rank[2][4:2]);
    c_freeze: cover property (@(posedge core_clk) !clk_en && irq_valid);
    c_zero_blocked: cover property (@(posedge core_clk)
        flag_word[0] && source_enable_word[0] && !elig[0]);
endmodule : iep_bank

// ===== tb/iep_core_model.sv
// Core side model that records the level of each request presented to it
`timescale 1ns/10ps
module iep_core_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic irq_valid,
    input wire logic [2:0] irq_priority,
    output logic [2:0] seen_level
);
    // The core only looks at the level while a request is presented
    always @(posedge core_clk) begin
        if (!rst_n) begin
            seen_level <= 3'h0;
        end else if (irq_valid === 1'b1) begin
            seen_level <= irq_priority;
        end
    end
endmodule : iep_core_model

// ===== tb/tb_iep_bank.sv
// Self-checking bench for the enable and priority bank
`timescale 1ns/10ps
module tb_iep_bank;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] src_req = 32'h00000000;
    logic irq_valid;
    logic [4:0] irq_source;
    logic [2:0] irq_priority;
    logic [1:0] irq_subpriority;
    logic [2:0] seen_level;
    logic [31:0] rv;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    always #20 core_clk = ~core_clk;
    iep_bank #(.NSRC(32)) dut_u (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .src_req(src_req), .irq_valid(irq_valid),
        .irq_source(irq_source), .irq_priority(irq_priority),
        .irq_subpriority(irq_subpriority));
    iep_core_model core_u (.core_clk(core_clk), .rst_n(rst_n), .irq_valid(irq_valid),
        .irq_priority(irq_priority), .seen_level(seen_level));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Write then read the same address on the very next edge, no gap
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask : wr_rd
    // Read data stands only in the cycle after the strobe, so sample there
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask : rd
    task automatic settle();
        repeat (3) @(posedge core_clk);
        #1;
    endtask : settle
    task automatic req(input logic [31:0] m);
        @(posedge core_clk);
        src_req <= m;
        @(posedge core_clk);
        src_req <= 32'h00000000;
        settle();
    endtask : req
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Valid, source, priority and subpriority packed as one value
    task automatic chk_irq(input logic [10:0] e);
        chk({21'h0, irq_valid, irq_source, irq_priority, irq_subpriority}, {21'h0, e});
    endtask : chk_irq
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    // Hang guard, far above the fewer than a hundred cycles the tests need
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            wrap_up();
        end
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(iep_pkg::OFS_ENABLE);
        chk(rv, 32'h00000000);
        rd(iep_pkg::OFS_PRIO0);
        chk(rv, 32'h00000000);
        $display("test reset values done");
        wr(iep_pkg::OFS_PRIO0, 32'hFFFFFFFF);
        rd(iep_pkg::OFS_PRIO0);
        chk(rv, 32'h1F1F1F1F);
        wr(iep_pkg::OFS_ENABLE, 32'hA5A5A5A5);
        rd(iep_pkg::OFS_ENABLE);
        chk(rv, 32'hA5A5A5A5);
        wr(iep_pkg::OFS_PRIO0 + 8'h10, 32'hE3E3E3E3);
        rd(iep_pkg::OFS_PRIO0 + 8'h10);
        chk(rv, 32'h03030303);
        wr(iep_pkg::OFS_PRIO0 + 8'h1C, 32'hFFFFFFFF);
        rd(iep_pkg::OFS_PRIO0 + 8'h1C);
        chk(rv, 32'h1F1F1F1F);
        rd(iep_pkg::OFS_STATUS);
        chk(rv, 32'h00000000);
        $display("test register access done");
        // Slot 3 level 7, slots 2 and 1 level 5 with subs 3 and 1, slot 0 off
        wr(iep_pkg::OFS_ENABLE, 32'hFFFFFFFF);
        wr(iep_pkg::OFS_PRIO0, 32'h1C171500);
        req(32'h00000007);
        chk_irq({1'b1, 5'h02, 3'h5, 2'h3});
        rd(iep_pkg::OFS_FLAG);
        chk(rv, 32'h00000007);
        rd(iep_pkg::OFS_STATUS);
        chk(rv, 32'h00000500);
        chk({29'h0, seen_level}, 32'h00000005);
        req(32'h00000008);
        chk_irq({1'b1, 5'h03, 3'h7, 2'h0});
        wr_rd(iep_pkg::OFS_ENABLE, 32'hFFFFFFF7);
        chk(rv, 32'hFFFFFFF7);
        settle();
        chk_irq({1'b1, 5'h02, 3'h5, 2'h3});
        $display("test arbitration done");
        // Clock enable low: a write must not land and the presented request must hold
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr(iep_pkg::OFS_ENABLE, 32'h00000000);
        clk_en <= 1'b1;
        rd(iep_pkg::OFS_ENABLE);
        chk(rv, 32'hFFFFFFF7);
        chk_irq({1'b1, 5'h02, 3'h5, 2'h3});
        $display("test clock enable freeze done");
        // Only the zero-priority source is flagged, so nothing may be presented
        wr(iep_pkg::OFS_FLAG, 32'h00000000);
        req(32'h00000001);
        chk({31'h0, irq_valid}, 32'h00000000);
        $display("test disabled priority done");
        // Reset in mid-run must clear every register and output again
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(iep_pkg::OFS_ENABLE);
        chk(rv, 32'h00000000);
        rd(iep_pkg::OFS_FLAG);
        chk(rv, 32'h00000000);
        chk_irq({1'b0, 5'h00, 3'h0, 2'h0});
        chk({29'h0, seen_level}, 32'h00000000);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule : tb_iep_bank
